// ==== rtl/ubrx_top.sv ====
// Purpose: Unblock channel supervision, trip permission and keying
// Assumes: All inputs are pins, asynchronous to ref_clk_i
// Notes:   Counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module ubrx_top #(
    parameter int TICK_CYCLES    = ubrx_pkg::TICK_CYCLES,
    parameter int UNBLOCK_WIN_MS = ubrx_pkg::UNBLOCK_WIN_MS,
    parameter int CHAN_FAIL_MS   = ubrx_pkg::CHAN_FAIL_MS,
    parameter int OPEN_BRK_MS    = ubrx_pkg::OPEN_BRK_MS
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic block_rx_i,
    input  wire logic unblock_rx_i,
    input  wire logic trip_fault_det_i,
    input  wire logic permissive_fault_detector_i,
    input  wire logic underreach_trip_det_i,
    input  wire logic transfer_trip_rx_i,
    input  wire logic utt_mode_i,
    input  wire logic permissive_mode_i,
    output logic      receiver_trip_relay_o,
    output logic      trip_o,
    output logic      channel_fail_alarm_o,
    output logic      lockout_o,
    output logic      key_unblock_o,
    output logic      power_boost_o,
    output logic      key_transfer_trip_o,
    output logic      open_breaker_o
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("ubrx_top TICK_CYCLES must be at least one");
    end

    // ======================================================================
    // State
    typedef struct packed {
        logic [TW-1:0]        tick_cnt;
        logic                 tick;
        ubrx_pkg::ubrx_state_t fsm;
        logic                 rr;
        logic                 trip;
        logic                 alarm;
        logic                 lockout;
        logic                 key_unblock;
        logic                 boost;
        logic                 key_tt;
        logic                 open_brk;
    } ubrx_top_t;

    ubrx_top_t st_q;
    ubrx_top_t st_d;

    logic [ubrx_pkg::PIN_W-1:0] pins_async;
    logic [ubrx_pkg::PIN_W-1:0] pins;
    logic                       block_s;
    logic                       unblock_s;
    logic                       trip_fd_s;
    logic                       perm_fd_s;
    logic                       ur_s;
    logic                       tt_rx_s;
    logic                       utt_s;
    logic                       perm_mode_s;
    logic                       win_done;
    logic                       chf_done;
    logic                       obk_done;
    logic                       chf_run;
    logic                       remote_trip;
    logic                       perm;
    logic                       tt_term;

    // ======================================================================
    // Pin synchronisers
    always_comb begin
        pins_async                            = '0;
        pins_async[ubrx_pkg::PIN_BLOCK]       = block_rx_i;
        pins_async[ubrx_pkg::PIN_UNBLOCK]     = unblock_rx_i;
        pins_async[ubrx_pkg::PIN_TRIP_FD]     = trip_fault_det_i;
        pins_async[ubrx_pkg::PIN_PERM_FD]     = permissive_fault_detector_i;
        pins_async[ubrx_pkg::PIN_UNDERREACH]  = underreach_trip_det_i;
        pins_async[ubrx_pkg::PIN_TT_RX]       = transfer_trip_rx_i;
        pins_async[ubrx_pkg::PIN_UTT_MODE]    = utt_mode_i;
        pins_async[ubrx_pkg::PIN_PERM_MODE]   = permissive_mode_i;
    end

    ubrx_sync #(
        .W       (ubrx_pkg::PIN_W),
        .RST_VAL (ubrx_pkg::PIN_RESET)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (pins_async),
        .sync_o    (pins)
    );

    assign block_s     = pins[ubrx_pkg::PIN_BLOCK];
    assign unblock_s   = pins[ubrx_pkg::PIN_UNBLOCK];
    assign trip_fd_s   = pins[ubrx_pkg::PIN_TRIP_FD];
    assign perm_fd_s   = pins[ubrx_pkg::PIN_PERM_FD];
    assign ur_s        = pins[ubrx_pkg::PIN_UNDERREACH];
    assign tt_rx_s     = pins[ubrx_pkg::PIN_TT_RX];
    assign utt_s       = pins[ubrx_pkg::PIN_UTT_MODE];
    assign perm_mode_s = pins[ubrx_pkg::PIN_PERM_MODE];

    // ======================================================================
    // Window timers
    assign chf_run     = !block_s && !unblock_s;
    assign remote_trip = utt_s ? tt_rx_s : unblock_s;

    ubrx_timer #(
        .LIMIT (UNBLOCK_WIN_MS)
    ) u_win_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (st_q.tick),
        .run_i     (st_q.fsm == ubrx_pkg::ST_WINDOW),
        .done_o    (win_done)
    );

    ubrx_timer #(
        .LIMIT (CHAN_FAIL_MS)
    ) u_chf_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (st_q.tick),
        .run_i     (chf_run),
        .done_o    (chf_done)
    );

    ubrx_timer #(
        .LIMIT (OPEN_BRK_MS)
    ) u_obk_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (st_q.tick),
        .run_i     (remote_trip),
        .done_o    (obk_done)
    );

    // ======================================================================
    // Permission terms
    // Block is checked here too, so permission drops the cycle block returns
    assign perm = unblock_s ||
                  (!block_s && (st_q.fsm == ubrx_pkg::ST_WINDOW) &&
                   !win_done && !chf_done);
    assign tt_term = tt_rx_s && (!perm_mode_s || perm_fd_s);

    // ======================================================================
    // Next state
    always_comb begin
        st_d = st_q;
        // Millisecond tick shared by all timers
        if (st_q.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            st_d.tick_cnt = '0;
            st_d.tick     = 1'b1;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + TW'(1);
            st_d.tick     = 1'b0;
        end

        case (st_q.fsm)
            ubrx_pkg::ST_GUARD: begin
                if (unblock_s) begin
                    st_d.fsm = ubrx_pkg::ST_UNBLK;
                end else if (!block_s) begin
                    st_d.fsm = ubrx_pkg::ST_WINDOW;
                end
            end
            ubrx_pkg::ST_WINDOW: begin
                if (unblock_s) begin
                    st_d.fsm = ubrx_pkg::ST_UNBLK;
                end else if (block_s) begin
                    st_d.fsm = ubrx_pkg::ST_GUARD;
                end else if (win_done || chf_done) begin
                    st_d.fsm = ubrx_pkg::ST_LOCKOUT;
                end
            end
            ubrx_pkg::ST_UNBLK: begin
                // Unblock vanishing without block is a dead channel: no fresh window
                if (block_s) begin
                    st_d.fsm = ubrx_pkg::ST_GUARD;
                end else if (!unblock_s) begin
                    st_d.fsm = ubrx_pkg::ST_LOCKOUT;
                end
            end
            ubrx_pkg::ST_LOCKOUT: begin
                if (block_s) begin
                    st_d.fsm = ubrx_pkg::ST_GUARD;
                end
            end
            default: begin
                st_d.fsm = ubrx_pkg::ST_GUARD;
            end
        endcase

        // Alarm holds until the guard tone returns
        if (chf_done) begin
            st_d.alarm = 1'b1;
        end else if (block_s) begin
            st_d.alarm = 1'b0;
        end
        st_d.lockout  = (st_d.fsm == ubrx_pkg::ST_LOCKOUT);
        st_d.open_brk = obk_done;

        if (utt_s) begin
            st_d.rr   = tt_term;
            st_d.trip = ur_s || tt_term || (obk_done && trip_fd_s);
        end else begin
            st_d.rr   = perm;
            st_d.trip = trip_fd_s && (perm || obk_done);
        end
        st_d.key_unblock = !utt_s && trip_fd_s;
        st_d.boost       = !utt_s && trip_fd_s;
        st_d.key_tt      = utt_s && ur_s;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q          <= '0;
            st_q.fsm      <= ubrx_pkg::ST_GUARD;
        end else begin
            st_q <= st_d;
        end
    end

    assign receiver_trip_relay_o = st_q.rr;
    assign trip_o                = st_q.trip;
    assign channel_fail_alarm_o  = st_q.alarm;
    assign lockout_o             = st_q.lockout;
    assign key_unblock_o         = st_q.key_unblock;
    assign power_boost_o         = st_q.boost;
    assign key_transfer_trip_o   = st_q.key_tt;
    assign open_breaker_o        = st_q.open_brk;

    // ======================================================================
    // Checks
    sequence seq_guard_lost;
        (st_q.fsm == ubrx_pkg::ST_GUARD) && !block_s && !unblock_s && !utt_s;
    endsequence

    sequence seq_window_open;
        (st_q.fsm == ubrx_pkg::ST_WINDOW) && !block_s && !unblock_s && !utt_s;
    endsequence

    AST_BLOCK_NO_PERM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        block_s && !unblock_s && !utt_s |=> !receiver_trip_relay_o && !chf_done)
        else $error("Permission or channel timer active while block received");

    AST_WINDOW_PERM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        seq_guard_lost ##1 (seq_window_open and (!win_done && !chf_done)) |=> receiver_trip_relay_o)
        else $error("No permission inside the unblock window");

    AST_LOCKOUT_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        seq_window_open and win_done |=> !receiver_trip_relay_o && lockout_o)
        else $error("Window expiry did not lock out");

    AST_UNBLOCK_PERM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        unblock_s && !utt_s |=> receiver_trip_relay_o)
        else $error("Unblock did not give permission");

    AST_UNBLOCK_STOPS_CHF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        unblock_s ##1 unblock_s |-> !chf_done)
        else $error("Channel timer ran during unblock");

    AST_CHF_ALARM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        chf_done && !unblock_s && !utt_s |=> channel_fail_alarm_o && !receiver_trip_relay_o)
        else $error("Channel failure not alarmed");

    AST_DCUB_TRIP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !utt_s && trip_fd_s && unblock_s |=> trip_o && receiver_trip_relay_o)
        else $error("Permission and trip detector did not trip");

    AST_OPEN_BRK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        obk_done && trip_fd_s |=> open_breaker_o && trip_o)
        else $error("Open breaker did not permit local trip");

    AST_KEY_UNBLOCK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        key_unblock_o |-> $past(trip_fd_s) && !$past(utt_s))
        else $error("Unblock keyed without local fault");

    AST_BOOST: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(key_unblock_o) |-> power_boost_o)
        else $error("Power boost missing during unblock keying");

    AST_UTT_DIRECT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        utt_s && ur_s |=> trip_o && key_transfer_trip_o)
        else $error("Underreach detector did not trip and key");

    AST_UTT_NONPERM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        utt_s && tt_rx_s && (!perm_mode_s || perm_fd_s) |=> trip_o && receiver_trip_relay_o)
        else $error("Transfer trip not honoured");

    AST_TICK_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_q.tick |-> (st_q.tick_cnt == TW'(0)) && ($past(st_q.tick_cnt) == TW'(TICK_CYCLES - 1)))
        else $error("Tick spacing wrong");

endmodule
`default_nettype wire

// ==== rtl/ubrx_pkg.sv ====
// Purpose: Shared constants for the unblock receiver logic
// Assumes: 250 MHz reference clock; 1 ms timing tick
// Notes:   Pin bit positions, state codes and timing figures
// ==========================================================================
package ubrx_pkg;

    // ======================================================================
    // Synchronised pin vector layout
    localparam int PIN_W           = 8;
    localparam int PIN_BLOCK       = 0;
    localparam int PIN_UNBLOCK     = 1;
    localparam int PIN_TRIP_FD     = 2;
    localparam int PIN_PERM_FD     = 3;
    localparam int PIN_UNDERREACH  = 4;
    localparam int PIN_TT_RX       = 5;
    localparam int PIN_UTT_MODE    = 6;
    localparam int PIN_PERM_MODE   = 7;

    // ======================================================================
    // Timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int TICK_NS         = 1000000;
    localparam int TICK_CYCLES     = (TICK_NS * 1000) / CLK_PERIOD_PS;
    localparam int UNBLOCK_WIN_MS  = 150;
    localparam int CHAN_FAIL_MS    = 150;
    localparam int OPEN_BRK_MS     = 1000;

    // ======================================================================
    // Channel supervision states
    typedef enum logic [3:0] {
        ST_GUARD   = 4'h1,
        ST_WINDOW  = 4'h2,
        ST_LOCKOUT = 4'h4,
        ST_UNBLK   = 4'h8
    } ubrx_state_t;

    localparam logic [PIN_W-1:0] PIN_RESET = 8'h01;

endpackage

// ==== rtl/ubrx_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk_i
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ubrx_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           ref_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic [W-1:0]   async_i,
    output logic      [W-1:0]   sync_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } ubrx_sync_t;

    ubrx_sync_t st_q;
    ubrx_sync_t st_d;

    // ======================================================================
    // Filter
    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            // Glitch of one cycle never reaches the output
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.out;

endmodule
`default_nettype wire

// ==== rtl/ubrx_timer.sv ====
// Purpose: Saturating tick counter for a timing window
// Assumes: tick_i is a one-cycle pulse
// Notes:   Clears at once when run_i falls
`timescale 1ns/1ps
`default_nettype none
module ubrx_timer #(
    parameter int LIMIT = 150
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic tick_i,
    input  wire logic run_i,
    output logic      done_o
);

    localparam int CW = $clog2(LIMIT + 1);

    if (LIMIT < 1) begin : g_bad_limit
        $error("ubrx_timer LIMIT must be at least one");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
    } ubrx_tmr_t;

    ubrx_tmr_t st_q;
    ubrx_tmr_t st_d;

    // ======================================================================
    // Counter
    always_comb begin
        st_d = st_q;
        if (!run_i) begin
            st_d.cnt = '0;
        end else if (tick_i && (st_q.cnt != CW'(LIMIT))) begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Resolution one tick: window may close up to one tick early
    assign done_o = (st_q.cnt == CW'(LIMIT));

endmodule
`default_nettype wire

// ==== verification/ubrx_partner.sv ====
// Purpose: Model of the remote carrier terminal and the local protective relay
// Assumes: Bench changes the controls just after a rising edge
// Notes:   Channel carries block, unblock or nothing, never both tones
`timescale 1ns/1ps
`default_nettype none
module ubrx_partner (
    input  wire logic [1:0] chan_i,
    input  wire logic       tt_i,
    input  wire logic       trip_fd_i,
    input  wire logic       perm_fd_i,
    input  wire logic       ur_i,
    output logic            block_rx_o,
    output logic            unblock_rx_o,
    output logic            transfer_trip_rx_o,
    output logic            trip_fault_det_o,
    output logic            permissive_fault_detector_o,
    output logic            underreach_trip_det_o
);
    // ======================================================================
    // Remote terminal: 0 block, 1 unblock, 2 channel lost
    // One decoder, so both tones can never show at once
    assign block_rx_o   = (chan_i == 2'h0);
    assign unblock_rx_o = (chan_i == 2'h1);
    assign transfer_trip_rx_o = tt_i;
    // ======================================================================
    // Local relay detectors
    assign trip_fault_det_o            = trip_fd_i;
    assign permissive_fault_detector_o = perm_fd_i;
    assign underreach_trip_det_o       = ur_i;
endmodule
`default_nettype wire

// ==== verification/ubrx_top_test.sv ====
// Purpose: Self-checking bench for the unblock receiver logic
// Assumes: Shortened counts: 4-cycle tick, 5/5/12 tick windows
// Notes:   Outputs sampled as {relay,trip,alarm,lockout,key,boost,tt,open}
`timescale 1ns/1ps
`default_nettype none
module ubrx_top_test;
    logic       ref_clk_i;
    logic       rst_n_i;
    logic [1:0] chan;
    logic       tt, trip_fd, perm_fd, ur, utt, pmode;
    logic       blk, unb, ttr, tfd, pfd, urd;
    wire logic [7:0] outs;
    logic       smp;
    logic [7:0] notes[$];
    logic [31:0] rng;
    int         mismatches;
    int         compares;

    // ======================================================================
    // Clock, 250 MHz
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    ubrx_partner u_far (
        .chan_i                      (chan),
        .tt_i                        (tt),
        .trip_fd_i                   (trip_fd),
        .perm_fd_i                   (perm_fd),
        .ur_i                        (ur),
        .block_rx_o                  (blk),
        .unblock_rx_o                (unb),
        .transfer_trip_rx_o          (ttr),
        .trip_fault_det_o            (tfd),
        .permissive_fault_detector_o (pfd),
        .underreach_trip_det_o       (urd)
    );

    ubrx_top #(
        .TICK_CYCLES    (4),
        .UNBLOCK_WIN_MS (5),
        .CHAN_FAIL_MS   (5),
        .OPEN_BRK_MS    (12)
    ) u_dut (
        .ref_clk_i                   (ref_clk_i),
        .rst_n_i                     (rst_n_i),
        .block_rx_i                  (blk),
        .unblock_rx_i                (unb),
        .trip_fault_det_i            (tfd),
        .permissive_fault_detector_i (pfd),
        .underreach_trip_det_i       (urd),
        .transfer_trip_rx_i          (ttr),
        .utt_mode_i                  (utt),
        .permissive_mode_i           (pmode),
        .receiver_trip_relay_o       (outs[7]),
        .trip_o                      (outs[6]),
        .channel_fail_alarm_o        (outs[5]),
        .lockout_o                   (outs[4]),
        .key_unblock_o               (outs[3]),
        .power_boost_o               (outs[2]),
        .key_transfer_trip_o         (outs[1]),
        .open_breaker_o              (outs[0])
    );

    // ======================================================================
    // Reporting
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction

    // ======================================================================
    // Driver helpers: inputs move only by NBA at the rising edge
    task automatic drive(input logic [1:0] c, input logic [5:0] v);
        @(posedge ref_clk_i);
        chan <= c;
        {tt, trip_fd, perm_fd, ur, utt, pmode} <= v;
    endtask

    // Note the expectation, let n cycles pass, then flag the sample point
    task automatic expect_after(input int n, input logic [7:0] exp);
        notes.push_back(exp);
        repeat (n) @(posedge ref_clk_i);
        smp <= 1'b1;
        @(posedge ref_clk_i);
        smp <= 1'b0;
    endtask

    // ======================================================================
    // Monitor: oldest note against what the outputs show
    always @(posedge ref_clk_i) begin
        if (smp) begin
            if (notes.size() == 0) begin
                mismatches = mismatches + 1;
                $display("BAD %0t sample without a note", $time);
            end else begin
                chk(outs, notes.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches = mismatches + 1;
        $display("BAD %0t run did not finish", $time);
        finish_test();
    end

    // ======================================================================
    // Scenarios
    initial begin
        rst_n_i = 1'b0;
        chan = 2'h0;
        {tt, trip_fd, perm_fd, ur, utt, pmode} = 6'h00;
        smp = 1'b0;
        rng = 32'd55568;
        mismatches = 0;
        compares = 0;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        expect_after(10, 8'h00);
        // Guard held: local fault keys unblock at full power, no trip
        drive(2'h0, 6'h10);
        expect_after(10, 8'h0c);
        drive(2'h0, 6'h00);
        expect_after(10, 8'h00);
        // One-cycle drop of block is filtered
        drive(2'h2, 6'h00);
        drive(2'h0, 6'h00);
        expect_after(10, 8'h00);
        // Block lost, no unblock: window then lockout with alarm
        drive(2'h2, 6'h00);
        expect_after(10, 8'h80);
        expect_after(30, 8'h30);
        // Unblock in lockout permits directly, trip follows detector
        drive(2'h1, 6'h00);
        expect_after(10, 8'hb0);
        drive(2'h1, 6'h10);
        expect_after(10, 8'hfc);
        expect_after(50, 8'hfd);
        drive(2'h0, 6'h00);
        expect_after(12, 8'h00);
        // Unblock straight from guard keeps channel-fail timer stopped
        drive(2'h1, 6'h00);
        expect_after(10, 8'h80);
        expect_after(30, 8'h80);
        drive(2'h2, 6'h00);
        expect_after(40, 8'h30);
        drive(2'h0, 6'h00);
        expect_after(12, 8'h00);
        // Underreaching scheme: local underreach trips and keys transfer
        drive(2'h0, 6'h06);
        expect_after(10, 8'h42);
        drive(2'h0, 6'h02);
        expect_after(10, 8'h00);
        // Received transfer trip in underreach mode, every permissive mode and permissive detector combination
        for (int m = 0; m < 4; m++) begin
            drive(2'h0, {1'b1, 1'b0, m[1], 1'b0, 1'b1, m[0]});
            expect_after(10, (m[0] && !m[1]) ? 8'h00 : 8'hc0);
            drive(2'h0, 6'h02);
            expect_after(10, 8'h00);
        end
        // Random detector and mode levels without a received trip
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            drive(2'h0, {2'h0, rng[0], 1'b0, 1'b1, rng[1]});
            expect_after(8, 8'h00);
        end
        repeat (4) @(posedge ref_clk_i);
        if (notes.size() != 0) begin
            mismatches = mismatches + 1;
            $display("BAD %0t notes left unchecked", $time);
        end
        finish_test();
    end
endmodule
`default_nettype wire
